// ==== common/i2m_pkg.sv ====
// i2m_pkg: constants and carrier types of the i2c master command engine
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`default_nettype none
package i2m_pkg;
  // ----------------------------------------------------------------
  // timing of the link clock domain
  // ----------------------------------------------------------------
  localparam int unsigned LINK_PERIOD_NS = 32;
  localparam int unsigned QTR_STD_NS     = 2500;  // quarter of a 100 kHz bit
  localparam int unsigned QTR_FAST_NS    = 625;   // quarter of a 400 kHz bit
  // round up so the bus never runs faster than its mode allows
  localparam logic [7:0] QTR_STD_CYC  = 8'((QTR_STD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] QTR_FAST_CYC = 8'((QTR_FAST_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  // ----------------------------------------------------------------
  // codes, limits and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]      SPEED_FAST  = 3'h4;
  localparam logic [3:0][2:0] PWR_PIO_IDS = {3'h7, 3'h3, 3'h2, 3'h1};
  localparam logic [5:0]      LEN_MIN     = 6'h01;
  localparam logic [5:0]      LEN_MAX     = 6'h20;
  localparam logic [2:0]      EVT_MAX     = 3'h5;
  localparam logic [3:0]      STP_EW_STOP = 4'h5;
  localparam logic [3:0]      STP_ER_STOP = 4'h7;
  localparam logic            LINE_IDLE   = 1'b1;
  localparam int              FIFO_DEPTH_DEF = 16;
  localparam logic [1:0]      ACT_END  = 2'h0;
  localparam logic [1:0]      ACT_COND = 2'h1;
  localparam logic [1:0]      ACT_BIT  = 2'h2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_EE_RD  = 3'h0,
    OP_EE_WR  = 3'h1,
    OP_EVT    = 3'h2,
    OP_RAW_RD = 3'h3,
    OP_RAW_WR = 3'h4
  } i2m_op_t;
  typedef struct packed {
    i2m_op_t     op;
    logic [2:0]  evt;
    logic [6:0]  dev;
    logic [15:0] mem;
    logic [5:0]  len;
  } i2m_cmd_t;
  typedef enum logic [4:0] {
    LK_IDLE  = 5'h01,
    LK_SEQ   = 5'h02,
    LK_FETCH = 5'h04,
    LK_COND  = 5'h08,
    LK_BIT   = 5'h10
  } i2m_lstate_t;
endpackage : i2m_pkg
`default_nettype wire

// ==== design/i2m_engine.sv ====
// i2m_engine: i2c master command engine with write fifo and synchronisers
`default_nettype none
// ----------------------------------------------------------------------
// three-stage synchroniser; output follows once stages two and three agree
// ----------------------------------------------------------------------
module i2m_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic s1, s2, s3;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q  <= INIT;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        q <= s3;
    end
  end
endmodule : i2m_sync
// ----------------------------------------------------------------------
// write data fifo; depth must be a power of two
// ----------------------------------------------------------------------
module i2m_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp;
  logic [AW:0]   cnt;
  logic          push, pop;
  assign in_ready  = cnt != (AW + 1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
      cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : i2m_fifo
// ----------------------------------------------------------------------
// top: command side on CORE_CLK, bus side on LINK_CLK
// ----------------------------------------------------------------------
module i2m_engine #(
  parameter int FIFO_DEPTH = i2m_pkg::FIFO_DEPTH_DEF
) (
  // clocks and reset
  input  wire logic               CORE_CLK,
  input  wire logic               RST_N,
  input  wire logic               LINK_CLK,
  // enable and power control
  input  wire logic               EN,
  input  wire logic [2:0]         SPEED,
  input  wire logic [2:0]         PWR_SEL,
  output logic      [3:0]         PWR_OUT,
  output logic      [3:0]         PWR_DRV,
  // commands
  input  wire logic               CMD_VALID,
  output logic                    CMD_READY,
  input  wire i2m_pkg::i2m_cmd_t  CMD,
  output logic                    CMD_ERR,
  output logic                    DONE,
  output logic                    NACK,
  output logic                    BUSY,
  // write data
  input  wire logic               WR_VALID,
  output logic                    WR_READY,
  input  wire logic [7:0]         WR_DATA,
  // read data
  output logic                    RD_VALID,
  output logic      [7:0]         RD_DATA,
  // open-drain bus pins
  input  wire logic               SCL_I,
  output logic                    SCL_O,
  output logic                    SCL_OE_N,
  input  wire logic               SDA_I,
  output logic                    SDA_O,
  output logic                    SDA_OE_N
);
  // ----------------------------------------------------------------
  // core domain
  // ----------------------------------------------------------------
  logic              en_d, fast_c, ctog, wack, pend, cmd_bad;
  logic              dtog_s, wreq_s, rtog_s, dtog_seen, wreq_seen, rtog_seen;
  logic              fifo_valid;
  logic [7:0]        fifo_data, wdata;
  i2m_pkg::i2m_cmd_t cmd_c;
  logic [3:0]        pwr_lvl;
  // link domain
  logic              lrst_s1, lrst_s2, lrst_s3, lrst_n;
  logic              ctog_s, wack_s, fast_s, sda_s, scl_s, ctog_seen, wack_seen;
  logic              dtog, wreq, rtog, nack_l, scl_o, sda_o, step, fin, nak, last, ee;
  logic              lat_stop, lat_rx, lat_nine, lat_one, lat_ack, lat_rep;
  logic              a_stop, a_fetch, a_rx, a_nine, a_one, a_ack, a_rep;
  logic [1:0]        a_kind, phase;
  logic [3:0]        stp, bits, ee_stop;
  logic [5:0]        cnt;
  logic [7:0]        qcnt, sh, next_sh, rdata_l, a_byte;
  i2m_pkg::i2m_cmd_t cmd_l;
  i2m_pkg::i2m_lstate_t lst;

  assign CMD_READY = en_d && !BUSY;
  assign cmd_bad   = (CMD.op == i2m_pkg::OP_EVT) ? (CMD.evt > i2m_pkg::EVT_MAX) :
                     (CMD.op > i2m_pkg::OP_RAW_WR) || (CMD.len < i2m_pkg::LEN_MIN) ||
                     (CMD.len > i2m_pkg::LEN_MAX);
  assign PWR_OUT   = PWR_DRV & pwr_lvl;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      en_d   <= 1'b0;
      fast_c <= 1'b0;
    end
    else
    begin
      en_d <= EN;
      if (EN && !en_d)
        fast_c <= (SPEED == i2m_pkg::SPEED_FAST);
    end
  end

  // one flop pair per power pin; an unlisted selection drives nothing
  for (genvar i = 0; i < 4; i++)
  begin : g_pwr
    always_ff @(posedge CORE_CLK)
    begin
      if (!RST_N)
      begin
        PWR_DRV[i] <= 1'b0;
        pwr_lvl[i] <= 1'b0;
      end
      else if (EN && !en_d)
      begin
        PWR_DRV[i] <= (PWR_SEL == i2m_pkg::PWR_PIO_IDS[i]);
        pwr_lvl[i] <= 1'b1;
      end
      else if (!EN && en_d)
        pwr_lvl[i] <= 1'b0;
    end
  end

  // command acceptance; cmd_c holds still until done comes back
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      BUSY    <= 1'b0;
      ctog    <= 1'b0;
      cmd_c   <= '0;
      CMD_ERR <= 1'b0;
      DONE    <= 1'b0;
      NACK    <= 1'b0;
    end
    else
    begin
      CMD_ERR <= 1'b0;
      DONE    <= 1'b0;
      if (CMD_VALID && CMD_READY)
      begin
        if (cmd_bad)
          CMD_ERR <= 1'b1;
        else
        begin
          cmd_c <= CMD;
          ctog  <= ~ctog;
          BUSY  <= 1'b1;
        end
      end
      if (dtog_s != dtog_seen)
      begin
        BUSY <= 1'b0;
        DONE <= 1'b1;
        NACK <= nack_l;  // quiet since dtog toggled
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      dtog_seen <= 1'b0;
      wreq_seen <= 1'b0;
      rtog_seen <= 1'b0;
    end
    else
    begin
      dtog_seen <= dtog_s;
      wreq_seen <= wreq_s;
      rtog_seen <= rtog_s;
    end
  end

  // byte fetch for the link; the engine waits here when the fifo is empty
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      pend  <= 1'b0;
      wack  <= 1'b0;
      wdata <= 8'h00;
    end
    else if (wreq_s != wreq_seen)
      pend <= 1'b1;
    else if (pend && fifo_valid)
    begin
      pend  <= 1'b0;
      wdata <= fifo_data;
      wack  <= ~wack;
    end
  end

  // read bytes have no back-pressure: the host takes each pulse
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      RD_VALID <= 1'b0;
      RD_DATA  <= 8'h00;
    end
    else
    begin
      RD_VALID <= (rtog_s != rtog_seen);
      if (rtog_s != rtog_seen)
        RD_DATA <= rdata_l;
    end
  end

  i2m_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CORE_CLK), .rst_n(RST_N), .in_valid(WR_VALID), .in_ready(WR_READY),
    .in_data(WR_DATA), .out_valid(fifo_valid), .out_ready(pend), .out_data(fifo_data)
  );
  i2m_sync u_s_dtog (.clk(CORE_CLK), .rst_n(RST_N), .d(dtog), .q(dtog_s));
  i2m_sync u_s_wreq (.clk(CORE_CLK), .rst_n(RST_N), .d(wreq), .q(wreq_s));
  i2m_sync u_s_rtog (.clk(CORE_CLK), .rst_n(RST_N), .d(rtog), .q(rtog_s));

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  always_ff @(posedge LINK_CLK)
  begin
    lrst_s1 <= RST_N;
    lrst_s2 <= lrst_s1;
    lrst_s3 <= lrst_s2;
  end
  assign lrst_n = lrst_s2 && lrst_s3;

  i2m_sync u_s_ctog (.clk(LINK_CLK), .rst_n(lrst_n), .d(ctog), .q(ctog_s));
  i2m_sync u_s_wack (.clk(LINK_CLK), .rst_n(lrst_n), .d(wack), .q(wack_s));
  i2m_sync u_s_fast (.clk(LINK_CLK), .rst_n(lrst_n), .d(fast_c), .q(fast_s));
  i2m_sync #(.INIT(i2m_pkg::LINE_IDLE)) u_s_sda (.clk(LINK_CLK), .rst_n(lrst_n), .d(SDA_I),
    .q(sda_s));
  i2m_sync #(.INIT(i2m_pkg::LINE_IDLE)) u_s_scl (.clk(LINK_CLK), .rst_n(lrst_n), .d(SCL_I),
    .q(scl_s));

  assign SCL_O    = 1'b0;
  assign SDA_O    = 1'b0;
  assign SCL_OE_N = scl_o;
  assign SDA_OE_N = sda_o;

  // quarter-bit ticks; a released clock line waits for a stretching slave
  always_ff @(posedge LINK_CLK)
  begin
    if (!lrst_n)
      qcnt <= 8'h00;
    else if (qcnt == 8'h00)
      qcnt <= (fast_s ? i2m_pkg::QTR_FAST_CYC : i2m_pkg::QTR_STD_CYC) - 8'h01;
    else
      qcnt <= qcnt - 8'h01;
  end
  assign step = (qcnt == 8'h00) && (scl_s || !scl_o);

  assign ee      = (cmd_l.op == i2m_pkg::OP_EE_RD) || (cmd_l.op == i2m_pkg::OP_EE_WR);
  assign ee_stop = (cmd_l.op == i2m_pkg::OP_EE_WR) ? i2m_pkg::STP_EW_STOP : i2m_pkg::STP_ER_STOP;
  assign last    = (cnt == cmd_l.len - 6'h01);
  assign next_sh = (bits < 4'h8) ? {sh[6:0], sda_s} : sh;
  assign nak     = nack_l || (lst == i2m_pkg::LK_BIT && bits == 4'h8 && !lat_rx && sda_s);
  assign fin     = step && (phase == 2'h3) && ((lst == i2m_pkg::LK_COND) ||
                   (lst == i2m_pkg::LK_BIT && bits == (lat_nine ? 4'h8 : 4'h7)));

  // sequence of bus actions per command step
  always_comb
  begin
    a_kind  = i2m_pkg::ACT_END;
    a_stop  = 1'b0;
    a_byte  = 8'h00;
    a_fetch = 1'b0;
    a_rx    = 1'b0;
    a_nine  = 1'b1;
    a_one   = 1'b0;
    a_ack   = 1'b0;
    a_rep   = 1'b0;
    case (cmd_l.op)
      i2m_pkg::OP_EE_WR, i2m_pkg::OP_EE_RD:
        case (stp)
          4'h0, 4'h4: a_kind = i2m_pkg::ACT_COND;
          4'h1, 4'h5:
          begin
            a_kind = i2m_pkg::ACT_BIT;
            a_byte = {cmd_l.dev, stp == 4'h5};
            if (cmd_l.op == i2m_pkg::OP_EE_WR && stp == 4'h4)
              a_kind = i2m_pkg::ACT_BIT;
          end
          4'h2, 4'h3:
          begin
            a_kind = i2m_pkg::ACT_BIT;
            a_byte = (stp == 4'h2) ? cmd_l.mem[15:8] : cmd_l.mem[7:0];
          end
          4'h6:
          begin
            a_kind = i2m_pkg::ACT_BIT;
            a_rx   = 1'b1;
            a_rep  = 1'b1;
            a_ack  = last;
          end
          4'h7: a_kind = i2m_pkg::ACT_COND;
          default: a_kind = i2m_pkg::ACT_END;
        endcase
      i2m_pkg::OP_EVT:
        if (stp == 4'h0)
        begin
          a_kind = (cmd_l.evt < 3'h3) ? i2m_pkg::ACT_COND : i2m_pkg::ACT_BIT;
          a_one  = 1'b1;
          a_rx   = (cmd_l.evt > 3'h3);
          a_ack  = (cmd_l.evt == 3'h5);
        end
      i2m_pkg::OP_RAW_RD:
        if (stp == 4'h0)
        begin
          a_kind = i2m_pkg::ACT_BIT;
          a_rx   = 1'b1;
          a_rep  = 1'b1;
          a_nine = !last;
        end
      i2m_pkg::OP_RAW_WR:
        if (stp == 4'h0)
        begin
          a_kind  = i2m_pkg::ACT_BIT;
          a_fetch = 1'b1;
          a_rep   = 1'b1;
        end
      default: a_kind = i2m_pkg::ACT_END;
    endcase
    // ee write: step 4 is the data phase, step 5 the stop
    if (cmd_l.op == i2m_pkg::OP_EE_WR && stp == 4'h4)
    begin
      a_kind  = i2m_pkg::ACT_BIT;
      a_fetch = 1'b1;
      a_rep   = 1'b1;
    end
    if (cmd_l.op == i2m_pkg::OP_EE_WR && stp == 4'h5)
      a_kind = i2m_pkg::ACT_COND;
    if (cmd_l.op == i2m_pkg::OP_EE_WR && stp > 4'h5)
      a_kind = i2m_pkg::ACT_END;
    a_stop = (stp == ee_stop) || (cmd_l.op == i2m_pkg::OP_EVT && cmd_l.evt == 3'h2);
  end

  // step and byte counters; a nack in an eeprom access skips to its stop
  always_ff @(posedge LINK_CLK)
  begin
    if (!lrst_n)
    begin
      stp <= 4'h0;
      cnt <= 6'h00;
    end
    else if (lst == i2m_pkg::LK_IDLE)
    begin
      stp <= 4'h0;
      cnt <= 6'h00;
    end
    else if (fin)
    begin
      if (ee && nak && stp < ee_stop)
      begin
        stp <= ee_stop;
        cnt <= 6'h00;
      end
      else if (lat_rep && !last)
        cnt <= cnt + 6'h01;
      else
      begin
        stp <= stp + 4'h1;
        cnt <= 6'h00;
      end
    end
  end

  // bus sequencer; no page splitting, the range is the issuer's concern
  always_ff @(posedge LINK_CLK)
  begin
    if (!lrst_n)
    begin
      lst       <= i2m_pkg::LK_IDLE;
      cmd_l     <= '0;
      ctog_seen <= 1'b0;
      wack_seen <= 1'b0;
      {dtog, wreq, rtog, nack_l} <= 4'h0;
      {lat_stop, lat_rx, lat_nine, lat_one, lat_ack, lat_rep} <= 6'h00;
      scl_o     <= i2m_pkg::LINE_IDLE;
      sda_o     <= i2m_pkg::LINE_IDLE;
      phase     <= 2'h0;
      bits      <= 4'h0;
      sh        <= 8'h00;
      rdata_l   <= 8'h00;
    end
    else
    begin
      case (lst)
        i2m_pkg::LK_IDLE:
          if (ctog_s != ctog_seen)
          begin
            ctog_seen <= ctog_s;
            cmd_l     <= cmd_c;
            nack_l    <= 1'b0;
            lst       <= i2m_pkg::LK_SEQ;
          end
        i2m_pkg::LK_SEQ:
        begin
          phase <= 2'h0;
          {lat_stop, lat_rx, lat_nine, lat_one, lat_ack, lat_rep} <=
            {a_stop, a_rx, a_nine, a_one, a_ack, a_rep};
          sh    <= a_byte;
          bits  <= a_one ? 4'h8 : 4'h0;
          if (a_kind == i2m_pkg::ACT_END)
          begin
            dtog <= ~dtog;
            lst  <= i2m_pkg::LK_IDLE;
          end
          else if (a_kind == i2m_pkg::ACT_COND)
            lst <= i2m_pkg::LK_COND;
          else if (a_fetch)
          begin
            wreq <= ~wreq;
            lst  <= i2m_pkg::LK_FETCH;
          end
          else
            lst <= i2m_pkg::LK_BIT;
        end
        i2m_pkg::LK_FETCH:
          if (wack_s != wack_seen)
          begin
            wack_seen <= wack_s;
            sh        <= wdata;  // held by the core until the next request
            lst       <= i2m_pkg::LK_BIT;
          end
        i2m_pkg::LK_COND:
          if (step)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: scl_o <= 1'b0;
              2'h1: sda_o <= !lat_stop;
              2'h2: scl_o <= 1'b1;
              default:
              begin
                sda_o <= lat_stop;  // edge with clock high: start or stop
                lst   <= i2m_pkg::LK_SEQ;
              end
            endcase
          end
        i2m_pkg::LK_BIT:
          if (step)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: scl_o <= 1'b0;
              2'h1: sda_o <= (bits == 4'h8) ? (!lat_rx || lat_ack) : (lat_rx || sh[7]);
              2'h2: scl_o <= 1'b1;
              default:
              begin
                sh <= next_sh;
                if (bits == 4'h8 && !lat_rx && sda_s)
                  nack_l <= 1'b1;
                if (fin)
                begin
                  lst <= i2m_pkg::LK_SEQ;
                  if (lat_rx && !lat_one)
                  begin
                    rdata_l <= next_sh;
                    rtog    <= ~rtog;
                  end
                end
                else
                  bits <= bits + 4'h1;
              end
            endcase
          end
        default: lst <= i2m_pkg::LK_IDLE;
      endcase
    end
  end
endmodule : i2m_engine
`default_nettype wire

// ==== verification/i2m_engine_asserts.sv ====
// checker: port assertions of the command engine
`default_nettype none
module i2m_engine_asserts (
  // clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RST_N,
  // power control
  input wire logic              EN,
  input wire logic [2:0]        PWR_SEL,
  input wire logic [3:0]        PWR_OUT,
  input wire logic [3:0]        PWR_DRV,
  // command side
  input wire logic              CMD_VALID,
  input wire logic              CMD_READY,
  input wire i2m_pkg::i2m_cmd_t CMD,
  input wire logic              CMD_ERR,
  input wire logic              DONE,
  input wire logic              BUSY
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  wire logic       tk = CMD_VALID && CMD_READY;
  wire logic [2:0] op = CMD.op;
  wire logic       ok = CMD.len >= 6'h01 && CMD.len <= 6'h20;
  // power pin gets a few cycles to follow the enable edge
  sequence s_on(logic [2:0] sel);
    $rose(EN) && PWR_SEL == sel ##1 EN [*5];
  endsequence
  AST_EE_BAD: assert property (tk && op <= 3'h1 && !ok |=> CMD_ERR && !BUSY)
    else $error("bad length taken");
  AST_EE_OK: assert property (tk && op == 3'h1 && ok |=> BUSY && !CMD_ERR)
    else $error("good write refused");
  AST_EVT_BAD: assert property (tk && op == 3'h2 && CMD.evt > 3'h5 |=> CMD_ERR)
    else $error("bad event taken");
  AST_EVT_OK: assert property (tk && op == 3'h2 && CMD.evt <= 3'h5 && ok |=> BUSY)
    else $error("good event refused");
  AST_RAW_RD: assert property (tk && op == 3'h3 && ok |=> BUSY)
    else $error("good read refused");
  AST_RAW_WR: assert property (tk && op == 3'h4 && CMD.len > 6'h20 |=> CMD_ERR)
    else $error("long write taken");
  AST_PWR_OFF: assert property (!EN [*8] |-> PWR_OUT == 4'h0)
    else $error("power pin high while off");
  AST_PWR_PIN: assert property (s_on(3'h7) |-> PWR_OUT == 4'h8)
    else $error("power pin not raised");
  AST_PWR_BAD: assert property (s_on(3'h5) |-> PWR_DRV == 4'h0)
    else $error("unlisted pin controlled");
  AST_DONE: assert property (DONE |-> !BUSY ##1 !DONE)
    else $error("done not a single pulse");
endmodule : i2m_engine_asserts
bind i2m_engine i2m_engine_asserts u_i2m_engine_asserts (.CORE_CLK(CORE_CLK),
  .RST_N(RST_N), .EN(EN), .PWR_SEL(PWR_SEL), .PWR_OUT(PWR_OUT), .PWR_DRV(PWR_DRV),
  .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD), .CMD_ERR(CMD_ERR),
  .DONE(DONE), .BUSY(BUSY));
`default_nettype wire

// ==== verification/i2m_slave_model.sv ====
// slave model: memory peripheral on the open-drain bus
`default_nettype none
module i2m_slave_model (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // own pull-down
  output logic     sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem[int];
  logic [7:0]  sh, dev_seen;
  logic [15:0] ptr;
  logic        rd = 1'b0;
  logic        ackme = 1'b0;
  int          bitc = 0;
  int          idx = 0;
  wire logic   tx = rd && idx > 0;
  initial sda_oe_n = 1'b1;
  // data edge with clock high: start or stop
  always @(sda)
    if (scl === 1'b1)
    begin
      bitc = 0;
      idx = 0;
      rd = 1'b0;
    end
  always @(posedge scl)
    if (bitc == 8)
    begin
      bitc = 0;
      // a master nack ends the read
      if (tx && !ackme)
      begin
        ptr++;
        rd = !sda;
      end
    end
    else
    begin
      sh = {sh[6:0], sda};
      bitc++;
      if (bitc == 8)
      begin
        ackme = !tx;
        if (idx == 0)
        begin
          dev_seen = sh;
          rd = sh[0];
        end
        else if (!rd && idx < 3)
          ptr = idx == 1 ? {sh, ptr[7:0]} : {ptr[15:8], sh};
        else if (!rd)
        begin
          mem[ptr] = sh;
          ptr++;
        end
        idx++;
      end
    end
  // a one bit is a release, read high through the pull-up
  always @(negedge scl)
    sda_oe_n = bitc == 8 ? !ackme : !tx || mem[ptr][7 - bitc];
endmodule : i2m_slave_model
`default_nettype wire

// ==== verification/i2m_engine_tb_top.sv ====
// testbench: engine against a byte model and a memory peripheral
`default_nettype none
module i2m_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] DEV = 7'h2a;
  localparam int         LIM = 20000;
  logic              core_clk = 1'b0;
  logic              link_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              en = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              wr_valid = 1'b0;
  logic [2:0]        speed = 3'h4;
  logic [2:0]        pwr_sel = 3'h0;
  logic [7:0]        wr_data = 8'h00;
  i2m_pkg::i2m_cmd_t cmd = '0;
  logic [3:0]        pwr_out;
  logic              cmd_ready, cmd_err, done, nack, wr_ready, rd_valid;
  logic [7:0]        rd_data;
  logic              scl_o, scl_oe_n, sda_o, sda_oe_n, s_oe_n;
  wire logic         scl = scl_oe_n ? 1'b1 : scl_o;
  wire logic         sda = (sda_oe_n ? 1'b1 : sda_o) & s_oe_n;
  int                fail_count = 0;
  int                compares = 0;
  logic [31:0]       rnd = 32'hd0ba;
  logic [7:0]        wq[$], got[$];
  logic [7:0]        em[int];
  initial forever #50 core_clk = ~core_clk;
  initial #7 forever #16 link_clk = ~link_clk;
  i2m_engine u_i2m_engine (.CORE_CLK(core_clk), .RST_N(rst_n), .LINK_CLK(link_clk),
    .EN(en), .SPEED(speed), .PWR_SEL(pwr_sel), .PWR_OUT(pwr_out), .PWR_DRV(),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD(cmd), .CMD_ERR(cmd_err),
    .DONE(done), .NACK(nack), .BUSY(), .WR_VALID(wr_valid), .WR_READY(wr_ready),
    .WR_DATA(wr_data), .RD_VALID(rd_valid), .RD_DATA(rd_data), .SCL_I(scl),
    .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n));
  i2m_slave_model u_i2m_slave_model (.scl(scl), .sda(sda), .sda_oe_n(s_oe_n));
  always @(negedge core_clk) if (rd_valid === 1'b1) got.push_back(rd_data);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // pushes queued bytes until the queue is empty or the fifo refuses, then offers the command
  task automatic run(input logic [2:0] op, ev, input logic [15:0] ma,
                     input logic [5:0] n, output int cyc);
    logic go, took, sent;
    int   n0;
    go = 1'b0;
    took = 1'b0;
    sent = 1'b0;
    n0 = wq.size();
    cmd = {op, ev, DEV, ma, n};
    for (cyc = 0; cyc < LIM; cyc++)
    begin
      @(negedge core_clk);
      if (took) void'(wq.pop_front());
      sent |= go;
      if (sent && (done === 1'b1 || cmd_err === 1'b1)) break;
      if (!sent && !cmd_valid && wr_ready !== 1'b1) chk(n0 - wq.size(), 16);
      cmd_valid = !sent && (cmd_valid || wq.size() == 0 || wr_ready !== 1'b1);
      go = cmd_valid && cmd_ready === 1'b1;
      wr_valid = wq.size() > 0;
      wr_data = wr_valid ? wq[0] : 8'h00;
      took = wr_valid && wr_ready === 1'b1;
    end
    wr_valid = 1'b0;
    cmd_valid = 1'b0;
    if (cyc == LIM)
    begin
      fail_count++;
      finish_test();
    end
  endtask : run
  initial
  begin
    logic [15:0] ma;
    logic [5:0]  n;
    int          c1, c2;
    logic [11:0] bad[6] = '{12'h000, 12'h221, 12'h600, 12'h821, 12'h581, 12'ha01};
    logic [11:0] raw[13] = '{12'h401, 12'h803, 12'h441, 12'h801, 12'h602, 12'h501,
                             12'h601, 12'h541, 12'h481, 12'h401, 12'h801, 12'h4c1, 12'h481};
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      en = 1'b0;
      repeat (8) @(negedge core_clk);
      chk(pwr_out, 0);
      pwr_sel = 3'(s);
      en = 1'b1;
      repeat (8) @(negedge core_clk);
      chk(pwr_out, s == 7 ? 8 : s inside {[1:3]} ? 1 << (s - 1) : 0);
    end
    foreach (bad[k])
    begin
      run(bad[k][11:9], bad[k][8:6], 16'h0000, bad[k][5:0], c1);
      chk(cmd_err, 1);
    end
    // the peripheral has no pages, so any range may be read back
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      ma = rnd[15:0];
      n = i == 0 ? 6'h20 : i == 1 ? 6'h01 : 6'(3 + rnd[19:16]);
      for (int j = 0; j < n; j++)
      begin
        rnd = lfsr(rnd);
        em[ma + 16'(j)] = rnd[7:0];
        wq.push_back(rnd[7:0]);
      end
      run(3'h1, 3'h0, ma, n, c1);
      chk(nack, 0);
      got.delete();
      run(3'h0, 3'h0, ma, n, c1);
      chk(got.size(), n);
      foreach (got[j]) chk(got[j], em[ma + 16'(j)]);
      chk(u_i2m_slave_model.dev_seen, {DEV, 1'b1});
    end
    wq = '{{DEV, 1'b0}, ma[15:8], ma[7:0], {DEV, 1'b1}, {DEV, 1'b0}};
    got.delete();
    foreach (raw[k])
    begin
      run(raw[k][11:9], raw[k][8:6], ma, raw[k][5:0], c1);
      chk(nack, raw[k] == 12'h4c1);
    end
    chk(got.size(), 3);
    foreach (got[j]) chk(got[j], em[ma + 16'(j)]);
    run(3'h2, 3'h2, ma, 6'h01, c1);
    en = 1'b0;
    repeat (8) @(negedge core_clk);
    speed = 3'h1;
    en = 1'b1;
    repeat (8) @(negedge core_clk);
    run(3'h2, 3'h2, ma, 6'h01, c2);
    // a stop spans three full quarters plus a wait for the first tick
    chk(c1 <= 45, 1);
    chk(c2 inside {[76:120]}, 1);
    finish_test();
  end
endmodule : i2m_engine_tb_top
`default_nettype wire
